// ---- hdl/pfs_flash_mem.sv ----
`timescale 1ns/100ps
`default_nettype none
module pfs_flash_mem
  import pfs_pkg::*;
(
  input  wire logic clk,
  pfs_mem_if.mem    port
);
  logic [WORD_W-1:0] cells [0:(1<<ADDR_W)-1];

  // ----------------------------------------------------------------
  // Array with registered read data
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (port.wr_en) begin
      cells[port.addr] <= port.wdata;
    end
    if (port.rd_en) begin
      port.rdata <= cells[port.addr];
    end
  end
endmodule
`default_nettype wire

// ---- hdl/pfs_mem_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface pfs_mem_if;
  import pfs_pkg::*;
  logic              rd_en;
  logic              wr_en;
  logic [ADDR_W-1:0] addr;
  logic [WORD_W-1:0] wdata;
  logic [WORD_W-1:0] rdata;
  modport ctl (output rd_en, wr_en, addr, wdata, input rdata);
  modport mem (input rd_en, wr_en, addr, wdata, output rdata);
endinterface
`default_nettype wire

// ---- hdl/pfs_pkg.sv ----
package pfs_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam int WORD_W = 14;
  localparam int REG_W  = 8;
  localparam int AXI_AW = 32;
  localparam int AXI_DW = 32;
  localparam int PWR_W  = 21;
  localparam int PRG_W  = 16;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [AXI_AW-1:0] OFS_CTRL   = 32'h0000_0000;
  localparam logic [AXI_AW-1:0] OFS_UNLOCK = 32'h0000_0004;
  localparam logic [AXI_AW-1:0] OFS_WLO    = 32'h0000_0008;
  localparam logic [AXI_AW-1:0] OFS_WHI    = 32'h0000_000C;
  localparam logic [AXI_AW-1:0] OFS_PLO    = 32'h0000_0010;
  localparam logic [AXI_AW-1:0] OFS_PHI    = 32'h0000_0014;

  // ----------------------------------------------------------------
  // Control register fields, high register widths
  // ----------------------------------------------------------------
  localparam int BIT_FETCH = 0;
  localparam int BIT_TRIG  = 1;
  localparam int BIT_MEN   = 2;
  localparam int BIT_ERASE = 4;
  localparam int BIT_LATCH = 5;
  localparam int BIT_CFG   = 6;
  localparam int HI_WORD_W = 6;
  localparam int HI_PTR_W  = 5;

  // ----------------------------------------------------------------
  // Reset values, keys, responses
  // ----------------------------------------------------------------
  localparam logic [REG_W-1:0]  CTRL_RST    = 8'h00;
  localparam logic [REG_W-1:0]  DATA_RST    = 8'h00;
  localparam logic [REG_W-1:0]  KEY_FIRST   = 8'h55;
  localparam logic [REG_W-1:0]  KEY_SECOND  = 8'hAA;
  localparam logic [WORD_W-1:0] ERASED_WORD = 14'h3FFF;
  localparam logic [1:0]        RESP_OKAY   = 2'h0;
  localparam logic [1:0]        RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ       = 20_000_000;
  localparam int PWRUP_MS     = 64;
  localparam int PWRUP_CYCLES = PWRUP_MS * (CLK_HZ / 1_000);
  localparam int PROG_US      = 2;
  localparam int PROG_CYCLES  = PROG_US * (CLK_HZ / 1_000_000);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    PFS_IDLE  = 4'b0001,
    PFS_FETCH = 4'b0010,
    PFS_LOAD  = 4'b0100,
    PFS_PROG  = 4'b1000
  } pfs_state_e;

  typedef enum logic [2:0] {
    RG_CTRL, RG_UNLOCK, RG_WLO, RG_WHI, RG_PLO, RG_PHI, RG_NONE
  } pfs_reg_e;

endpackage

// ---- hdl/pfs_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module pfs_top #(
  parameter int PWRUP_LEN = pfs_pkg::PWRUP_CYCLES
) (
  input  wire logic                         clk,
  input  wire logic                         reset_n,
  input  wire logic [pfs_pkg::AXI_AW-1:0]   s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output var  logic                         s_axi_awready,
  input  wire logic [pfs_pkg::AXI_DW-1:0]   s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output var  logic                         s_axi_wready,
  output var  logic [1:0]                   s_axi_bresp,
  output var  logic                         s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [pfs_pkg::AXI_AW-1:0]   s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output var  logic                         s_axi_arready,
  output var  logic [pfs_pkg::AXI_DW-1:0]   s_axi_rdata,
  output var  logic [1:0]                   s_axi_rresp,
  output var  logic                         s_axi_rvalid,
  input  wire logic                         s_axi_rready
);
  import pfs_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  pfs_mem_if mem_bus ();

  logic [AXI_AW-1:0] aw_addr,  next_aw_addr;
  logic [REG_W-1:0]  w_byte,   next_w_byte;
  logic              w_lane,   next_w_lane;
  logic              next_awready, next_wready, next_bvalid;
  logic              next_arready, next_rvalid;
  logic [1:0]        next_bresp, next_rresp;
  logic [AXI_DW-1:0] next_rdata;

  pfs_state_e        state, next_state;
  logic [REG_W-1:0]  ctrl, next_ctrl;
  logic [REG_W-1:0]  word_lo, next_word_lo;
  logic [HI_WORD_W-1:0] word_hi, next_word_hi;
  logic [REG_W-1:0]  ptr_lo, next_ptr_lo;
  logic [HI_PTR_W-1:0] ptr_hi, next_ptr_hi;
  logic              key_half, next_key_half;
  logic              armed, next_armed;
  logic [PRG_W-1:0]  prog_cnt, next_prog_cnt;
  logic [PWR_W-1:0]  pwr_cnt, next_pwr_cnt;
  logic              pwr_done, next_pwr_done;

  logic              wr_do;
  pfs_reg_e          wr_idx;
  logic              prog_end;

  function automatic pfs_reg_e reg_decode(input logic [AXI_AW-1:0] a);
    pfs_reg_e r;
    r = RG_NONE;
    unique case (a)
      OFS_CTRL:   r = RG_CTRL;
      OFS_UNLOCK: r = RG_UNLOCK;
      OFS_WLO:    r = RG_WLO;
      OFS_WHI:    r = RG_WHI;
      OFS_PLO:    r = RG_PLO;
      OFS_PHI:    r = RG_PHI;
      default:    r = RG_NONE;
    endcase
    return r;
  endfunction

  assign wr_do    = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_idx   = reg_decode(aw_addr);
  assign prog_end = (state == PFS_PROG) &&
                    (prog_cnt == PRG_W'(PROG_CYCLES - 1));

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  always_comb begin
    next_aw_addr  = aw_addr;
    next_w_byte   = w_byte;
    next_w_lane   = w_lane;
    next_awready  = s_axi_awready;
    next_wready   = s_axi_wready;
    next_bvalid   = s_axi_bvalid;
    next_bresp    = s_axi_bresp;
    next_arready  = s_axi_arready;
    next_rvalid   = s_axi_rvalid;
    next_rresp    = s_axi_rresp;
    next_rdata    = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_addr = s_axi_awaddr;
      next_awready = 1'b0;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_byte = s_axi_wdata[REG_W-1:0];
      next_w_lane = s_axi_wstrb[0];
      next_wready = 1'b0;
    end
    if (wr_do) begin
      next_bvalid = 1'b1;
      next_bresp  = (wr_idx == RG_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid  = 1'b0;
      next_awready = 1'b1;
      next_wready  = 1'b1;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_arready = 1'b0;
      next_rvalid  = 1'b1;
      next_rresp   = RESP_OKAY;
      next_rdata   = '0;
      unique case (reg_decode(s_axi_araddr))
        RG_CTRL:   next_rdata[REG_W-1:0] = ctrl;
        RG_UNLOCK: next_rdata = '0;
        RG_WLO:    next_rdata[REG_W-1:0] = word_lo;
        RG_WHI:    next_rdata[HI_WORD_W-1:0] = word_hi;
        RG_PLO:    next_rdata[REG_W-1:0] = ptr_lo;
        RG_PHI:    next_rdata[HI_PTR_W-1:0] = ptr_hi;
        RG_NONE:   next_rresp = RESP_SLVERR;
      endcase
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid  = 1'b0;
      next_arready = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_addr       <= '0;
      w_byte        <= '0;
      w_lane        <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_rdata   <= '0;
    end else begin
      aw_addr       <= next_aw_addr;
      w_byte        <= next_w_byte;
      w_lane        <= next_w_lane;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rresp   <= next_rresp;
      s_axi_rdata   <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Power-up write blocking
  // ----------------------------------------------------------------
  always_comb begin
    next_pwr_cnt  = pwr_cnt;
    next_pwr_done = pwr_done;
    if (!pwr_done) begin
      next_pwr_cnt = pwr_cnt + 1'b1;
      if (pwr_cnt == PWR_W'(PWRUP_LEN - 1)) begin
        next_pwr_done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pwr_cnt  <= '0;
      pwr_done <= 1'b0;
    end else begin
      pwr_cnt  <= next_pwr_cnt;
      pwr_done <= next_pwr_done;
    end
  end

  // ----------------------------------------------------------------
  // Registers and flash sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state    = state;
    next_ctrl     = ctrl;
    next_word_lo  = word_lo;
    next_word_hi  = word_hi;
    next_ptr_lo   = ptr_lo;
    next_ptr_hi   = ptr_hi;
    next_key_half = key_half;
    next_armed    = armed;
    next_prog_cnt = prog_cnt;
    mem_bus.rd_en = 1'b0;
    mem_bus.wr_en = 1'b0;
    mem_bus.addr  = {ptr_hi, ptr_lo};
    mem_bus.wdata = ctrl[BIT_ERASE] ? ERASED_WORD : {word_hi, word_lo};

    if (wr_do && w_lane) begin
      next_key_half = 1'b0;
      next_armed    = 1'b0;
      unique case (wr_idx)
        RG_CTRL: begin
          next_ctrl[BIT_CFG]   = w_byte[BIT_CFG];
          next_ctrl[BIT_LATCH] = w_byte[BIT_LATCH];
          next_ctrl[BIT_ERASE] = w_byte[BIT_ERASE];
          next_ctrl[BIT_MEN]   = w_byte[BIT_MEN];
          if (w_byte[BIT_FETCH]) begin
            next_ctrl[BIT_FETCH] = 1'b1;
          end
          if (w_byte[BIT_TRIG] && w_byte[BIT_MEN] && armed && pwr_done
              && state == PFS_IDLE && !ctrl[BIT_FETCH]) begin
            next_ctrl[BIT_TRIG] = 1'b1;
            next_state    = PFS_PROG;
            next_prog_cnt = '0;
          end
        end
        RG_UNLOCK: begin
          next_key_half = (w_byte == KEY_FIRST);
          next_armed    = key_half && (w_byte == KEY_SECOND);
        end
        RG_WLO:  next_word_lo = w_byte;
        RG_WHI:  next_word_hi = w_byte[HI_WORD_W-1:0];
        RG_PLO:  next_ptr_lo  = w_byte;
        RG_PHI:  next_ptr_hi  = w_byte[HI_PTR_W-1:0];
        RG_NONE: next_key_half = 1'b0;
      endcase
    end

    unique case (state)
      PFS_IDLE: begin
        if (ctrl[BIT_FETCH]) begin
          mem_bus.rd_en = 1'b1;
          next_state    = PFS_FETCH;
        end
      end
      PFS_FETCH: begin
        next_state = PFS_LOAD;
      end
      PFS_LOAD: begin
        next_word_hi = mem_bus.rdata[WORD_W-1:REG_W];
        next_word_lo = mem_bus.rdata[REG_W-1:0];
        next_ctrl[BIT_FETCH] = 1'b0;
        next_state = PFS_IDLE;
      end
      PFS_PROG: begin
        next_prog_cnt = prog_cnt + 1'b1;
        if (prog_end) begin
          mem_bus.wr_en = !ctrl[BIT_LATCH];
          next_ctrl[BIT_TRIG]  = 1'b0;
          next_ctrl[BIT_ERASE] = 1'b0;
          next_state = PFS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state    <= PFS_IDLE;
      ctrl     <= CTRL_RST;
      word_lo  <= DATA_RST;
      word_hi  <= '0;
      ptr_lo   <= DATA_RST;
      ptr_hi   <= '0;
      key_half <= 1'b0;
      armed    <= 1'b0;
      prog_cnt <= '0;
    end else begin
      state    <= next_state;
      ctrl     <= next_ctrl;
      word_lo  <= next_word_lo;
      word_hi  <= next_word_hi;
      ptr_lo   <= next_ptr_lo;
      ptr_hi   <= next_ptr_hi;
      key_half <= next_key_half;
      armed    <= next_armed;
      prog_cnt <= next_prog_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Flash array
  // ----------------------------------------------------------------
  pfs_flash_mem u_mem (
    .clk  (clk),
    .port (mem_bus.mem)
  );

endmodule
`default_nettype wire

// ---- tb/pfs_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
module pfs_monitor
  import pfs_pkg::*;
(
  input wire logic                       clk,
  input wire logic                       reset_n,
  input wire logic [pfs_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic                       s_axi_awvalid,
  input wire logic                       s_axi_awready,
  input wire logic [pfs_pkg::AXI_DW-1:0] s_axi_wdata,
  input wire logic [3:0]                 s_axi_wstrb,
  input wire logic                       s_axi_wvalid,
  input wire logic                       s_axi_wready,
  input wire logic [pfs_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic                       s_axi_arvalid,
  input wire logic                       s_axi_arready,
  input wire logic [pfs_pkg::AXI_DW-1:0] s_axi_rdata,
  input wire logic                       s_axi_rvalid,
  input wire logic                       s_axi_rready
);
  // ----------------------------------------
  // Capture of bus traffic
  // ----------------------------------------
  logic [31:0] ar_q, next_ar_q;
  logic [7:0]  phi_q, plo_q, next_phi_q, next_plo_q;
  logic        ctl_seen, next_ctl_seen, wtake;

  always_comb begin
    wtake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            && s_axi_wstrb[0];
    next_ar_q = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : ar_q;
    next_phi_q = (wtake && s_axi_awaddr == OFS_PHI) ? s_axi_wdata[7:0]
                                                     : phi_q;
    next_plo_q = (wtake && s_axi_awaddr == OFS_PLO) ? s_axi_wdata[7:0]
                                                     : plo_q;
    next_ctl_seen = ctl_seen || (wtake && s_axi_awaddr == OFS_CTRL);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ar_q     <= 32'hFFFF_FFFF;
      phi_q    <= 8'h00;
      plo_q    <= 8'h00;
      ctl_seen <= 1'b0;
    end else begin
      ar_q     <= next_ar_q;
      phi_q    <= next_phi_q;
      plo_q    <= next_plo_q;
      ctl_seen <= next_ctl_seen;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_RD_ANS: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer not one cycle after request");
  AST_R_HOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before accepted");
  AST_WHI_TOP: assert property (
    s_axi_rvalid && ar_q == OFS_WHI |-> s_axi_rdata[31:6] == 26'h0)
    else $error("word high upper bits not zero");
  AST_PHI_TOP: assert property (
    s_axi_rvalid && ar_q == OFS_PHI |-> s_axi_rdata[31:5] == 27'h0)
    else $error("pointer high upper bits not zero");
  AST_PHI_VAL: assert property (
    s_axi_rvalid && ar_q == OFS_PHI |-> s_axi_rdata[4:0] == phi_q[4:0])
    else $error("pointer high lost written bits");
  AST_PLO_VAL: assert property (
    s_axi_rvalid && ar_q == OFS_PLO |-> s_axi_rdata == {24'h0, plo_q})
    else $error("pointer low lost written value");
  AST_UNLK: assert property (
    s_axi_rvalid && ar_q == OFS_UNLOCK |-> s_axi_rdata == 32'h0)
    else $error("unlock location returned data");
  AST_MEN_RST: assert property (
    s_axi_rvalid && ar_q == OFS_CTRL && !ctl_seen |-> !s_axi_rdata[BIT_MEN])
    else $error("enable set without a control write");
endmodule

bind pfs_top pfs_monitor mon_u (
  .clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready
);
`default_nettype wire

// ---- tb/test_program_flash_self_access.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_program_flash_self_access
  import pfs_pkg::*;
;
  logic        clk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rdat;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  int          err_count, num_checks, i;
  logic [31:0] amap [6] = '{OFS_CTRL, OFS_UNLOCK, OFS_WLO, OFS_WHI,
                            OFS_PLO, OFS_PHI};

  pfs_top #(.PWRUP_LEN(32)) dut_u (
    .clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready
  );

  always #25 clk = ~clk;

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [31:0] a);
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        rdat = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rc(input string nm, input logic [31:0] a, e);
    rd(a);
    chk(nm, e, rdat);
  endtask

  task automatic prog(input logic [7:0] c);
    wr(OFS_UNLOCK, KEY_FIRST);
    wr(OFS_UNLOCK, KEY_SECOND);
    wr(OFS_CTRL, c);
  endtask

  task automatic wait_clr(input int b);
    for (int n = 0; n < 100; n++) begin
      rd(OFS_CTRL);
      if (rdat[b] === 1'b0) break;
    end
    if (rdat[b] !== 1'b0) begin
      err_count++;
      $display("[ERR] wait_clr expected 0 seen %b", rdat[b]);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    give_verdict();
  end

  initial begin
    {clk, reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'h1;
    err_count = 0;
    num_checks = 0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    for (i = 0; i < 6; i++) rc("reset value", amap[i], 32'h0);
    wr(32'h0000_0018, 8'h01);
    chk("bresp unmapped", {30'h0, RESP_SLVERR}, {30'h0, resp});
    rc("unmapped data", 32'h0000_0018, 32'h0);
    chk("rresp unmapped", {30'h0, RESP_SLVERR}, {30'h0, resp});
    wr(OFS_UNLOCK, KEY_FIRST);
    rc("unlock readback", OFS_UNLOCK, 32'h0);
    wr(OFS_PHI, 8'hFF);
    chk("bresp okay", {30'h0, RESP_OKAY}, {30'h0, resp});
    rc("pointer high", OFS_PHI, 32'h0000_001F);
    chk("rresp okay", {30'h0, RESP_OKAY}, {30'h0, resp});
    wr(OFS_WHI, 8'hFF);
    rc("word high", OFS_WHI, 32'h0000_003F);
    wr(OFS_PHI, 8'h1A);
    wr(OFS_PLO, 8'h5C);
    wr(OFS_WHI, 8'h2B);
    wr(OFS_WLO, 8'h3C);
    rc("pointer low", OFS_PLO, 32'h0000_005C);
    // Write with byte lane off must leave the register alone
    s_axi_wstrb <= 4'h0;
    wr(OFS_PLO, 8'hA5);
    s_axi_wstrb <= 4'h1;
    rc("lane off", OFS_PLO, 32'h0000_005C);
    wr(OFS_CTRL, 8'h06);
    rc("no unlock", OFS_CTRL, 32'h0000_0004);
    prog(8'h06);
    rc("trigger set", OFS_CTRL, 32'h0000_0006);
    wr(OFS_CTRL, 8'h04);
    rc("zero write", OFS_CTRL, 32'h0000_0006);
    wait_clr(BIT_TRIG);
    chk("trigger done", 32'h0000_0004, rdat);
    wr(OFS_WLO, 8'h00);
    wr(OFS_WHI, 8'h00);
    wr(OFS_CTRL, 8'h05);
    wait_clr(BIT_FETCH);
    chk("fetch done", 32'h0000_0004, rdat);
    rc("read high", OFS_WHI, 32'h0000_002B);
    rc("read low", OFS_WLO, 32'h0000_003C);
    wr(OFS_WLO, 8'h11);
    wr(OFS_CTRL, 8'h00);
    prog(8'h02);
    rc("no enable", OFS_CTRL, 32'h0);
    wr(OFS_CTRL, 8'h01);
    wait_clr(BIT_FETCH);
    rc("array kept", OFS_WLO, 32'h0000_003C);
    prog(8'h16);
    wait_clr(BIT_TRIG);
    chk("erase done", 32'h0000_0004, rdat);
    wr(OFS_CTRL, 8'h05);
    wait_clr(BIT_FETCH);
    rc("erased high", OFS_WHI, 32'h0000_003F);
    rc("erased low", OFS_WLO, 32'h0000_00FF);
    // Latch-only trigger completes without touching the array
    wr(OFS_WHI, 8'h01);
    wr(OFS_WLO, 8'h02);
    prog(8'h26);
    wait_clr(BIT_TRIG);
    chk("latch done", 32'h0000_0024, rdat);
    wr(OFS_CTRL, 8'h05);
    wait_clr(BIT_FETCH);
    rc("latch kept", OFS_WLO, 32'h0000_00FF);
    // Second reset: trigger inside the power-up span is refused
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    prog(8'h06);
    rc("powerup block", OFS_CTRL, 32'h0000_0004);
    rc("reset word", OFS_WLO, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
